//--- inc/gbs_defines.vh
`ifndef GBS_DEFINES_VH
`define GBS_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------------------------------
`define GBS_OFS_CTRL 6'h00
`define GBS_OFS_SLIP_REF 6'h04
`define GBS_OFS_VOLT_WIN 6'h08
`define GBS_OFS_PHASE_WIN 6'h0c
`define GBS_OFS_SLIP_WIN 6'h10
`define GBS_OFS_CLOSE_DLY 6'h14
`define GBS_OFS_ATTEMPTS 6'h18
`define GBS_OFS_RECLOSE_DLY 6'h1c
`define GBS_OFS_HOLD_TIME 6'h20
`define GBS_OFS_SYNC_TMO 6'h24
`define GBS_OFS_PI_GAIN 6'h28
`define GBS_OFS_PI_STAB 6'h2c
`define GBS_OFS_STATUS 6'h30
`define GBS_CFG_WORDS 12

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define GBS_CTRL_VM_EN 0
`define GBS_CTRL_REARM 1
`define GBS_CTRL_ALM_ATT 2
`define GBS_CTRL_ALM_TMO 3
`define GBS_CTRL_SAVE 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GBS_RST_CTRL 16'h0001
`define GBS_RST_VOLT_WIN 16'h0020
`define GBS_RST_PHASE_WIN 16'h0040
`define GBS_RST_SLIP_WIN 16'h0010
`define GBS_RST_CLOSE_DLY 16'h0004
`define GBS_RST_ATTEMPTS 16'h0001
`define GBS_RST_RECLOSE_DLY 16'h0064
`define GBS_RST_HOLD_TIME 16'h00c8
`define GBS_RST_PI_GAIN 16'h0100
`define GBS_RST_PI_STAB 16'h0010
`define GBS_NV_TAG 8'ha5

// ----------------------------------------------------------------
// Mode switch codes and timing
// ----------------------------------------------------------------
`define GBS_MODE_OFF 2'h0
`define GBS_MODE_RUN 2'h1
`define GBS_MODE_CHECK 2'h2
`define GBS_MODE_PERM 2'h3
`define GBS_CLK_NS 20
`define GBS_TICK_NS 1000000
`define GBS_TICK_CYCLES (`GBS_TICK_NS / `GBS_CLK_NS)

`endif

//--- core/gbs_sync.v
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// [R1] Four modes; off means no activity
// [R2] Run closes breaker, bias held during closure
// [R3] Run stops on hold expiry or aux
// [R4] Optional automatic re-arm after disconnect
// [R5] Check matches but never closes
// [R6] Permissive: no bias, close only within limits
// [R7] Voltage raise/lower until inside window
// [R8] Voltage match enable; permissive only verifies
// [R9] Zero slip reference selects phase PI
// [R10] Non-zero slip reference regulates slip PI
// [R11] Close only when all conditions hold
// [R12] Anticipate zero phase; windows gate closure
// [R13] Limit attempts, reclose delay between them
// [R14] Exhausted attempts force off until toggled
// [R15] Alarm on attempt limit when enabled
// [R16] Attempt count one means single shot
// [R17] Set points persist only after save
// [R18] Hold time: relay on, closed check
// [R19] Sync timeout forces off; zero disables
// [R20] Off drops closure, clears reclose delay
`include "gbs_defines.vh"

module gbs_sync #(
  parameter TICK_CYCLES = `GBS_TICK_CYCLES
)(
  input wire clk_sys_in,
  input wire rstn_in,
  input wire ce_in,
  input wire [5:0] avm_address_in,
  input wire avm_read_in,
  input wire avm_write_in,
  input wire [31:0] avm_writedata_in,
  input wire [3:0] avm_byteenable_in,
  output reg [31:0] avm_readdata_out,
  output reg avm_waitrequest_out,
  input wire [1:0] mode_sel_in,
  input wire breaker_aux_contact_in,
  input wire [15:0] volt_bus_in,
  input wire [15:0] volt_util_in,
  input wire [15:0] phase_err_in,
  input wire [15:0] slip_meas_in,
  output reg breaker_close_out,
  output reg alarm_out,
  output reg volt_raise_out,
  output reg volt_lower_out,
  output reg [15:0] speed_bias_out,
  output reg speed_bias_valid_out
);

  // ----------------------------------------------------------------
  // States, one-hot
  // ----------------------------------------------------------------
  localparam [6:0] S_OFF = 7'h01;
  localparam [6:0] S_MATCH = 7'h02;
  localparam [6:0] S_CLOSE = 7'h04;
  localparam [6:0] S_VERIFY = 7'h08;
  localparam [6:0] S_RECLOSE = 7'h10;
  localparam [6:0] S_DONE = 7'h20;
  localparam [6:0] S_LOCK = 7'h40;

  reg [15:0] cfg_reg [0:`GBS_CFG_WORDS-1];
  // Non-volatile image: no reset, survives power loss
  reg [15:0] nv_mem [0:`GBS_CFG_WORDS-1];
  reg [7:0] nv_tag [0:`GBS_CFG_WORDS-1];
  reg restore_reg;
  reg [2:0] mode_sync_reg [0:1];
  reg [2:0] aux_sync_reg;
  reg [1:0] mode_reg;
  reg aux_reg;
  reg [6:0] state_reg;
  reg [15:0] attempts_reg;
  reg [15:0] timer_reg;
  reg [15:0] tmo_reg;
  reg [31:0] tick_cnt_reg;
  reg tick_reg;
  reg signed [23:0] integ_reg;
  integer i;

  function [15:0] cfg_default;
    input integer idx;
    begin
      case (idx)
        0: cfg_default = `GBS_RST_CTRL;
        2: cfg_default = `GBS_RST_VOLT_WIN;
        3: cfg_default = `GBS_RST_PHASE_WIN;
        4: cfg_default = `GBS_RST_SLIP_WIN;
        5: cfg_default = `GBS_RST_CLOSE_DLY;
        6: cfg_default = `GBS_RST_ATTEMPTS;
        7: cfg_default = `GBS_RST_RECLOSE_DLY;
        8: cfg_default = `GBS_RST_HOLD_TIME;
        10: cfg_default = `GBS_RST_PI_GAIN;
        11: cfg_default = `GBS_RST_PI_STAB;
        default: cfg_default = 16'h0000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Measurement conditions
  // ----------------------------------------------------------------
  wire [15:0] slip_ref = cfg_reg[1];
  wire vm_en = cfg_reg[0][`GBS_CTRL_VM_EN];
  wire signed [16:0] v_diff = $signed({1'b0, volt_bus_in}) - $signed({1'b0, volt_util_in});
  wire [16:0] v_mag = v_diff[16] ? (17'h00000 - v_diff) : v_diff;
  wire v_ok = !vm_en || (v_mag <= {1'b0, cfg_reg[2]}); // [R8] [R11]
  // Advance angle: slip times breaker delay, ahead of zero phase
  wire signed [32:0] advance = $signed(slip_meas_in) * $signed({1'b0, cfg_reg[5]}); // [R12]
  wire signed [33:0] phase_pred = $signed(phase_err_in) + advance;
  wire [33:0] p_mag = phase_pred[33] ? (34'h000000000 - phase_pred) : phase_pred;
  wire [15:0] s_mag = slip_meas_in[15] ? (16'h0000 - slip_meas_in) : slip_meas_in;
  wire p_ok = p_mag <= {18'h00000, cfg_reg[3]}; // [R12]
  wire s_ok = s_mag <= cfg_reg[4]; // [R12]
  wire all_ok = v_ok && p_ok && s_ok; // [R11]
  // Zero reference selects phase lock, otherwise slip regulation
  wire signed [16:0] pi_err = (slip_ref == 16'h0000) ? -$signed({phase_err_in[15], phase_err_in}) : // [R9]
    $signed({slip_ref[15], slip_ref}) - $signed({slip_meas_in[15], slip_meas_in}); // [R10]
  wire signed [33:0] p_term = pi_err * $signed({1'b0, cfg_reg[10]});
  wire signed [33:0] i_term = pi_err * $signed({1'b0, cfg_reg[11]});
  wire signed [23:0] bias_sum = integ_reg + $signed({{8{p_term[33]}}, p_term[23:8]});
  wire biasing = (mode_reg == `GBS_MODE_RUN || mode_reg == `GBS_MODE_CHECK) &&
    (state_reg == S_MATCH || state_reg == S_CLOSE || state_reg == S_RECLOSE); // [R2] [R5] [R6]
  wire limit_hit = (attempts_reg >= cfg_reg[6]); // [R13] [R16]
  wire tmo_hit = (cfg_reg[9] != 16'h0000) && (tmo_reg >= cfg_reg[9]); // [R19]
  wire run_like = (mode_reg == `GBS_MODE_RUN || mode_reg == `GBS_MODE_PERM);

  // ----------------------------------------------------------------
  // Pin synchronisers: accept when stages two and three agree
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      mode_sync_reg[0] <= 3'h0;
      mode_sync_reg[1] <= 3'h0;
      aux_sync_reg <= 3'h0;
      mode_reg <= `GBS_MODE_OFF;
      aux_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      mode_sync_reg[0] <= {mode_sync_reg[0][1:0], mode_sel_in[0]};
      mode_sync_reg[1] <= {mode_sync_reg[1][1:0], mode_sel_in[1]};
      aux_sync_reg <= {aux_sync_reg[1:0], breaker_aux_contact_in};
      if (mode_sync_reg[0][2] == mode_sync_reg[0][1] && mode_sync_reg[1][2] == mode_sync_reg[1][1])
        mode_reg <= {mode_sync_reg[1][2], mode_sync_reg[0][2]};
      if (aux_sync_reg[2] == aux_sync_reg[1])
        aux_reg <= aux_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick for all timers
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      tick_reg <= (tick_cnt_reg == TICK_CYCLES - 1);
      if (tick_cnt_reg == TICK_CYCLES - 1)
        tick_cnt_reg <= 32'h00000000;
      else
        tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then a single-cycle answer
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      avm_waitrequest_out <= 1'b1;
      avm_readdata_out <= 32'h00000000;
      restore_reg <= 1'b1;
      for (i = 0; i < `GBS_CFG_WORDS; i = i + 1)
        cfg_reg[i] <= cfg_default(i);
    end
    else if (ce_in)
    begin
      // Working set reloads from the saved image after every reset
      if (restore_reg)
      begin
        restore_reg <= 1'b0;
        for (i = 0; i < `GBS_CFG_WORDS; i = i + 1)
          if (nv_tag[i] == `GBS_NV_TAG)
            cfg_reg[i] <= nv_mem[i]; // [R17]
      end
      if (!avm_waitrequest_out)
        avm_waitrequest_out <= 1'b1;
      else if (avm_read_in || avm_write_in)
        avm_waitrequest_out <= 1'b0;
      if (avm_read_in && avm_waitrequest_out)
      begin
        if (avm_address_in == `GBS_OFS_STATUS)
          avm_readdata_out <= {attempts_reg, 6'h00, aux_reg, mode_reg, state_reg[6:1], alarm_out};
        else if (avm_address_in[5:2] < `GBS_CFG_WORDS && avm_address_in[1:0] == 2'h0)
          avm_readdata_out <= {16'h0000, cfg_reg[avm_address_in[5:2]]};
        else
          avm_readdata_out <= 32'h00000000;
      end
      // Write lands at the edge the master sees waitrequest low
      if (avm_write_in && !avm_waitrequest_out && avm_address_in[1:0] == 2'h0 &&
        avm_address_in[5:2] < `GBS_CFG_WORDS)
      begin
        if (avm_byteenable_in[0])
          cfg_reg[avm_address_in[5:2]][7:0] <= avm_writedata_in[7:0];
        if (avm_byteenable_in[1])
          cfg_reg[avm_address_in[5:2]][15:8] <= avm_writedata_in[15:8];
      end
    end
  end

  // Save copies the working set; stale values are kept otherwise
  always @(posedge clk_sys_in)
  begin
    if (ce_in && avm_write_in && !avm_waitrequest_out && avm_address_in == `GBS_OFS_CTRL &&
      avm_byteenable_in[0] && avm_writedata_in[`GBS_CTRL_SAVE])
      for (i = 0; i < `GBS_CFG_WORDS; i = i + 1)
      begin
        nv_mem[i] <= cfg_reg[i]; // [R17]
        nv_tag[i] <= `GBS_NV_TAG;
      end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= S_OFF;
      attempts_reg <= 16'h0000;
      timer_reg <= 16'h0000;
      tmo_reg <= 16'h0000;
      breaker_close_out <= 1'b0;
      alarm_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (tick_reg)
        timer_reg <= timer_reg + 16'h0001;
      // Timeout runs only while run is selected
      if (mode_reg != `GBS_MODE_RUN || state_reg == S_DONE || state_reg == S_LOCK)
        tmo_reg <= 16'h0000;
      else if (tick_reg)
        tmo_reg <= tmo_reg + 16'h0001; // [R19]
      if (mode_reg == `GBS_MODE_OFF)
      begin
        state_reg <= S_OFF; // [R1] [R20]
        breaker_close_out <= 1'b0; // [R20]
        alarm_out <= 1'b0;
        attempts_reg <= 16'h0000;
        timer_reg <= 16'h0000;
      end
      else if (tmo_hit && state_reg != S_VERIFY)
      begin
        state_reg <= S_LOCK; // [R19]
        breaker_close_out <= 1'b0;
        alarm_out <= cfg_reg[0][`GBS_CTRL_ALM_TMO];
      end
      else
        case (state_reg)
          S_OFF:
          begin
            state_reg <= S_MATCH;
            attempts_reg <= 16'h0000;
          end
          S_MATCH:
            // Check mode never closes
            if (all_ok && run_like)
            begin
              state_reg <= S_CLOSE; // [R2] [R6] [R11] [R5]
              breaker_close_out <= 1'b1;
              attempts_reg <= attempts_reg + 16'h0001;
              timer_reg <= 16'h0000;
            end
          S_CLOSE:
            if (aux_reg)
            begin
              state_reg <= S_VERIFY; // [R3]
              breaker_close_out <= 1'b0;
              timer_reg <= 16'h0000;
            end
            else if (timer_reg >= cfg_reg[8] || mode_reg == `GBS_MODE_CHECK ||
              (mode_reg == `GBS_MODE_PERM && !all_ok))
            begin
              breaker_close_out <= 1'b0; // [R3] [R18] [R6]
              timer_reg <= 16'h0000;
              if (limit_hit)
              begin
                state_reg <= S_LOCK; // [R14] [R16]
                alarm_out <= cfg_reg[0][`GBS_CTRL_ALM_ATT]; // [R15]
              end
              else
                state_reg <= S_RECLOSE; // [R13]
            end
          S_VERIFY:
            // Breaker must stay shut for the hold time to count
            if (!aux_reg)
            begin
              timer_reg <= 16'h0000;
              if (limit_hit)
              begin
                state_reg <= S_LOCK; // [R14]
                alarm_out <= cfg_reg[0][`GBS_CTRL_ALM_ATT]; // [R15]
              end
              else
                state_reg <= S_RECLOSE;
            end
            else if (timer_reg >= cfg_reg[8])
              state_reg <= S_DONE; // [R18]
          S_RECLOSE:
            if (timer_reg >= cfg_reg[7])
              state_reg <= S_MATCH; // [R13]
          S_DONE:
            if (cfg_reg[0][`GBS_CTRL_REARM] && !aux_reg)
            begin
              state_reg <= S_MATCH; // [R4]
              attempts_reg <= 16'h0000;
            end
          S_LOCK:
            state_reg <= S_LOCK; // [R14]
          default:
            state_reg <= S_OFF;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // Network bias commands
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      integ_reg <= 24'h000000;
      speed_bias_out <= 16'h0000;
      speed_bias_valid_out <= 1'b0;
      volt_raise_out <= 1'b0;
      volt_lower_out <= 1'b0;
    end
    else if (ce_in)
    begin
      speed_bias_valid_out <= biasing && tick_reg; // [R2] [R6]
      // Integrator cleared while idle so re-entry starts clean
      if (!biasing)
        integ_reg <= 24'h000000;
      else if (tick_reg)
      begin
        integ_reg <= integ_reg + $signed({{8{i_term[33]}}, i_term[23:8]}); // [R9] [R10]
        speed_bias_out <= bias_sum[15:0];
      end
      volt_raise_out <= biasing && vm_en && !v_ok && v_diff[16]; // [R7] [R8]
      volt_lower_out <= biasing && vm_en && !v_ok && !v_diff[16]; // [R7] [R8]
    end
  end

endmodule

//--- sim/gbs_sync_chk.sv
`timescale 1ns/1ps
`include "gbs_defines.vh"
module gbs_sync_chk #(
  parameter TICK_CYCLES = 4
)(
  input wire clk_sys_in,
  input wire rstn_in,
  input wire ce_in,
  input wire avm_read_in,
  input wire avm_write_in,
  input wire avm_waitrequest_out,
  input wire [1:0] mode_sel_in,
  input wire breaker_aux_contact_in,
  input wire breaker_close_out,
  input wire alarm_out,
  input wire volt_raise_out,
  input wire volt_lower_out,
  input wire speed_bias_valid_out
);
  // Mode pin age; the pin crosses a 3-flop synchronizer, so judge it only once settled
  reg [1:0] mode_last_reg;
  reg [3:0] mode_age_reg;
  wire quiet = !volt_raise_out && !volt_lower_out && !speed_bias_valid_out;
  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      mode_last_reg <= 2'h0;
      mode_age_reg <= 4'h0;
    end
    else
    begin
      mode_last_reg <= mode_sel_in;
      if (mode_sel_in != mode_last_reg)
        mode_age_reg <= 4'h0;
      else if (mode_age_reg != 4'hf)
        mode_age_reg <= mode_age_reg + 4'h1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence s_held(logic [1:0] m);
    mode_sel_in == m && mode_age_reg >= 4'h6;
  endsequence
  sequence s_aux_in_run;
    (mode_sel_in == `GBS_MODE_RUN && breaker_aux_contact_in) [*6];
  endsequence
  chk_off_quiet: assert property (s_held(`GBS_MODE_OFF) |-> quiet && !breaker_close_out)
    else $error("activity while off");
  chk_check_no_close: assert property (s_held(`GBS_MODE_CHECK) |-> !breaker_close_out)
    else $error("closure in check mode");
  chk_perm_no_bias: assert property (s_held(`GBS_MODE_PERM) |-> quiet)
    else $error("bias sent in permissive mode");
  chk_volt_one_way: assert property (!(volt_raise_out && volt_lower_out))
    else $error("raise and lower together");
  chk_aux_ends_close: assert property (s_aux_in_run |-> !breaker_close_out)
    else $error("closure held after aux closed");
  chk_alarm_held: assert property (alarm_out && mode_sel_in != `GBS_MODE_OFF && mode_age_reg >= 4'h6 |=> alarm_out)
    else $error("alarm dropped outside off");
  chk_bus_answer: assert property (ce_in && (avm_read_in || avm_write_in) && avm_waitrequest_out |=> !avm_waitrequest_out)
    else $error("bus not answered in one cycle");
  chk_wait_pulse: assert property (!avm_waitrequest_out |=> avm_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
endmodule

//--- sim/gbs_brk_model.sv
`timescale 1ns/1ps
module gbs_brk_model(
  input wire clk_sys_in,
  input wire rstn_in,
  input wire close_in,
  input wire obey_in,
  input wire trip_in,
  input wire [7:0] lag_in,
  output reg aux_out
);
  reg [7:0] lag_reg;
  // Latches closed like a real breaker; only a trip opens it, lag sets prompt or slow
  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      aux_out <= 1'b0;
      lag_reg <= 8'h00;
    end
    else if (trip_in)
    begin
      aux_out <= 1'b0;
      lag_reg <= 8'h00;
    end
    else if (close_in && obey_in && !aux_out)
    begin
      aux_out <= (lag_reg == lag_in);
      lag_reg <= lag_reg + 8'h01;
    end
    else
      lag_reg <= 8'h00;
  end
endmodule

//--- sim/gbs_sync_tb.sv
`timescale 1ns/1ps
`include "gbs_defines.vh"
module gbs_sync_tb;
  reg clk_sys_in = 1'b0;
  reg rstn_in = 1'b0;
  reg [5:0] adr = 6'h00;
  reg rd_en = 1'b0;
  reg wr_en = 1'b0;
  reg [31:0] wdat = 32'h0;
  reg [1:0] mode = 2'h0;
  reg [15:0] vb = 16'h1000;
  reg [15:0] pe = 16'h0000;
  reg [15:0] sm = 16'h0000;
  reg obey = 1'b1;
  reg trip = 1'b0;
  reg cls_q = 1'b0;
  reg [31:0] got;
  wire [31:0] rdat;
  wire [15:0] bias;
  wire wreq, cls, alm, rai, low, bval, aux;
  integer errors = 0;
  integer checks_done = 0;
  integer n_close = 0;
  integer n_bias = 0;
  integer n_val = 0;
  integer n_raise = 0;
  integer cyc = 0;
  integer t_fall = 0;
  integer gap = 0;
  integer c0, b0;
  always #10 clk_sys_in = ~clk_sys_in;
  gbs_sync #(.TICK_CYCLES(4)) gbs_sync_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(1'b1),
    .avm_address_in(adr), .avm_read_in(rd_en), .avm_write_in(wr_en), .avm_writedata_in(wdat),
    .avm_byteenable_in(4'hf), .avm_readdata_out(rdat), .avm_waitrequest_out(wreq), .mode_sel_in(mode),
    .breaker_aux_contact_in(aux), .volt_bus_in(vb), .volt_util_in(16'h1000), .phase_err_in(pe),
    .slip_meas_in(sm), .breaker_close_out(cls), .alarm_out(alm), .volt_raise_out(rai),
    .volt_lower_out(low), .speed_bias_out(bias), .speed_bias_valid_out(bval));
  gbs_brk_model gbs_brk_model_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .close_in(cls),
    .obey_in(obey), .trip_in(trip), .lag_in(8'h0c), .aux_out(aux));
  // Event counters; reclose gap is measured fall to next rise
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    cls_q <= cls;
    if (cls === 1'b1 && cls_q === 1'b0)
    begin
      n_close <= n_close + 1;
      gap <= cyc - t_fall;
    end
    if (cls === 1'b0 && cls_q === 1'b1)
      t_fall <= cyc;
    if (bval === 1'b1)
      n_val <= n_val + 1;
    if (bval === 1'b1 && cls === 1'b1)
      n_bias <= n_bias + 1;
    if (rai === 1'b1)
      n_raise <= n_raise + 1;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input integer e, input integer g);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  end
  endtask
  // Held until waitrequest is seen low; a spare edge keeps requests apart
  task bus(input w, input [5:0] a, input [31:0] d);
    integer n;
  begin
    n = 0;
    adr <= a;
    wdat <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk_sys_in);
    while (wreq !== 1'b0 && n < 50)
    begin
      @(posedge clk_sys_in);
      n = n + 1;
    end
    got = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk_sys_in);
  end
  endtask
  task go(input [1:0] m, input integer n);
  begin
    mode <= m;
    repeat (n) @(posedge clk_sys_in);
  end
  endtask
  task wait_cls(input v);
    integer n;
  begin
    n = 0;
    while (cls !== v && n < 200)
    begin
      @(posedge clk_sys_in);
      n = n + 1;
    end
  end
  endtask
  task tally_and_finish;
  begin
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // Watchdog; the whole sequence needs about 1100 cycles
  initial
  begin
    repeat (4000) @(posedge clk_sys_in);
    errors = errors + 1;
    $display("ERROR watchdog expected done seen running");
    tally_and_finish;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    bus(0, `GBS_OFS_ATTEMPTS, 0);
    chk("attempts", 1, got);
    bus(0, `GBS_OFS_HOLD_TIME, 0);
    chk("hold", 32'hc8, got);
    bus(1, 6'h3c, 32'h1234);
    bus(0, 6'h3c, 0);
    chk("unmapped", 0, got);
    bus(1, `GBS_OFS_HOLD_TIME, 32'hffff0005);
    bus(0, `GBS_OFS_HOLD_TIME, 0);
    chk("hold write", 5, got);
    // Check mode: bus low, so raise, but never close
    vb <= 16'h0f00;
    c0 = n_close;
    go(`GBS_MODE_CHECK, 60);
    chk("raise", 1, n_raise > 0);
    vb <= 16'h1100;
    go(`GBS_MODE_CHECK, 40);
    chk("lower", 1, {31'h0, low});
    vb <= 16'h1000;
    go(`GBS_MODE_CHECK, 40);
    chk("raise idle", 0, {31'h0, rai});
    chk("check close", 0, n_close - c0);
    // Permissive: slip 0x10 times delay 4 leads the phase error
    obey <= 1'b0;
    pe <= 16'h0030;
    sm <= 16'h0010;
    go(`GBS_MODE_PERM, 40);
    chk("perm lead", 0, {31'h0, cls});
    // Closure lasts only the hold time, so count rises, not the level
    pe <= 16'hffd0;
    c0 = n_close;
    go(`GBS_MODE_PERM, 40);
    chk("perm close", 1, n_close - c0);
    // Toggle off to leave lockout, else the next checks see nothing
    vb <= 16'h0f00;
    go(`GBS_MODE_OFF, 10);
    c0 = n_close;
    go(`GBS_MODE_PERM, 40);
    chk("perm volt", 0, n_close - c0);
    vb <= 16'h1000;
    pe <= 16'h2000;
    go(`GBS_MODE_PERM, 40);
    chk("perm phase", 0, n_close - c0);
    // Run with a slow breaker, then trip it for re-arm
    pe <= 16'h0010;
    sm <= 16'h0000;
    obey <= 1'b1;
    go(`GBS_MODE_OFF, 10);
    bus(1, `GBS_OFS_CTRL, 32'h3);
    c0 = n_close;
    b0 = n_bias;
    go(`GBS_MODE_RUN, 0);
    wait_cls(1'b1);
    wait_cls(1'b0);
    chk("aux", 1, {31'h0, aux});
    chk("bias in close", 1, n_bias > b0);
    // Positive phase error must pull the bias negative
    chk("bias sign", 1, {31'h0, bias[15]});
    go(`GBS_MODE_RUN, 60);
    chk("one close", 1, n_close - c0);
    trip <= 1'b1;
    go(`GBS_MODE_RUN, 1);
    trip <= 1'b0;
    go(`GBS_MODE_RUN, 100);
    chk("rearm", 2, n_close - c0);
    // Breaker never closes: two shots, alarm, then single shot
    obey <= 1'b0;
    trip <= 1'b1;
    go(`GBS_MODE_OFF, 10);
    bus(1, `GBS_OFS_CTRL, 32'h5);
    bus(1, `GBS_OFS_ATTEMPTS, 32'h2);
    bus(1, `GBS_OFS_RECLOSE_DLY, 32'h3);
    c0 = n_close;
    go(`GBS_MODE_RUN, 200);
    chk("shots", 2, n_close - c0);
    chk("reclose gap", 1, gap > 8);
    chk("alarm", 1, {31'h0, alm});
    go(`GBS_MODE_RUN, 60);
    chk("forced off", 2, n_close - c0);
    go(`GBS_MODE_OFF, 10);
    chk("alarm off", 0, {31'h0, alm});
    bus(1, `GBS_OFS_ATTEMPTS, 32'h1);
    go(`GBS_MODE_RUN, 100);
    chk("single shot", 3, n_close - c0);
    // Sync timeout of 5 ticks (20 cycles) with phase far out
    go(`GBS_MODE_OFF, 10);
    bus(1, `GBS_OFS_CTRL, 32'h9);
    bus(1, `GBS_OFS_SYNC_TMO, 32'h5);
    pe <= 16'h2000;
    c0 = n_close;
    go(`GBS_MODE_RUN, 60);
    chk("timeout alarm", 1, {31'h0, alm});
    b0 = n_val;
    go(`GBS_MODE_RUN, 20);
    chk("timeout quiet", 0, n_val - b0 + n_close - c0);
    // Saved set points survive reset, unsaved edits do not
    go(`GBS_MODE_OFF, 10);
    bus(1, `GBS_OFS_VOLT_WIN, 32'h30);
    bus(1, `GBS_OFS_CTRL, 32'h11);
    bus(1, `GBS_OFS_VOLT_WIN, 32'h50);
    bus(1, `GBS_OFS_PHASE_WIN, 32'h55);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    bus(0, `GBS_OFS_VOLT_WIN, 0);
    chk("saved", 32'h30, got);
    bus(0, `GBS_OFS_PHASE_WIN, 0);
    chk("unsaved", 32'h40, got);
    tally_and_finish;
  end
endmodule
bind gbs_sync gbs_sync_chk #(.TICK_CYCLES(TICK_CYCLES)) gbs_sync_chk_inst (.clk_sys_in(clk_sys_in),
  .rstn_in(rstn_in), .ce_in(ce_in), .avm_read_in(avm_read_in), .avm_write_in(avm_write_in),
  .avm_waitrequest_out(avm_waitrequest_out), .mode_sel_in(mode_sel_in),
  .breaker_aux_contact_in(breaker_aux_contact_in), .breaker_close_out(breaker_close_out),
  .alarm_out(alarm_out), .volt_raise_out(volt_raise_out), .volt_lower_out(volt_lower_out),
  .speed_bias_valid_out(speed_bias_valid_out));
